/* File: shared/sdc_consts.svh */
// offsets, field positions, reset values and timing counts of the decimator
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH
`define SDC_SYS_CLK_HZ     100000000
`define SDC_MOD_RATE_HZ    32768
`define SDC_MOD_DIV        (`SDC_SYS_CLK_HZ / `SDC_MOD_RATE_HZ)
`define SDC_OFF_MODE       8'h00
`define SDC_OFF_CONFIG     8'h04
`define SDC_OFF_WORD       8'h08
`define SDC_OFF_RESULT     8'h0c
`define SDC_OFF_STATUS     8'h10
`define SDC_OFF_MASK       8'h14
`define SDC_MODE_CHOP_DIS  3
`define SDC_STAT_READY     0
`define SDC_WORD_RESET     8'h45
`define SDC_WORD_MIN_CHOP  8'h0d
`define SDC_WORD_MIN_BYP   8'h03
`define SDC_SETTLE_CHOP    2'h1
`define SDC_SETTLE_BYP     2'h2
`endif

/* File: shared/sdc_pkg.sv */
// types shared by the sigma-delta decimator
package sdc_pkg;
   typedef logic signed [35:0] sdc_acc_type;
   typedef enum logic [1:0] {PH_FIRST, PH_SECOND, PH_THIRD} sdc_phase_type;
endpackage

/* File: hdl/sdc_decimator.sv */
// sinc3 decimator with chop averaging, apb registers and ready interrupt
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "sdc_consts.svh"

module sdc_decimator (
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        mod_bit_i,
   output logic             mod_tick_o,
   output logic             chop_pol_o,
   output logic      [2:0]  range_o,
   output logic      [3:0]  channel_o,
   output logic             irq_o
);
   logic [11:0]          tick_cnt_reg;
   logic                 mod_tick_reg;
   logic                 chop_dis_reg;
   logic [7:0]           config_reg;
   logic [7:0]           word_reg;
   logic                 mask_reg;
   logic                 ready_reg;
   logic                 ready_next;
   logic [23:0]          result_reg;
   logic                 restart_reg;
   logic                 pready_reg;
   logic                 pslverr_reg;
   logic [31:0]          prdata_reg;
   logic                 irq_reg;
   logic                 pol_reg;
   logic [10:0]          samp_cnt_reg;
   logic [1:0]           settle_reg;
   sdc_pkg::sdc_phase_type phase_reg;
   sdc_pkg::sdc_acc_type integ_reg [3];
   sdc_pkg::sdc_acc_type dly_reg [3];
   sdc_pkg::sdc_acc_type comb_w [4];
   sdc_pkg::sdc_acc_type prev_reg;
   sdc_pkg::sdc_acc_type filt_w;
   sdc_pkg::sdc_acc_type avg_w;
   sdc_pkg::sdc_acc_type conv_w;
   sdc_pkg::sdc_acc_type sample_w;
   logic [7:0]           eff_word;
   logic [10:0]          dec_len;
   logic                 dec_done;
   logic                 conv_done;
   logic                 settled;
   logic                 result_wr;
   logic                 acc;
   logic                 wr;
   logic                 mapped;
   logic [31:0]          rdata_w;

   // modulator rate enable from the system clock
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i || tick_cnt_reg == 12'(`SDC_MOD_DIV - 1)) begin
         tick_cnt_reg <= 12'h000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 12'h001;
      end
      mod_tick_reg <= resetn_i && tick_cnt_reg == 12'(`SDC_MOD_DIV - 1);
   end

   // apb access qualifiers; one wait state so every output is a flop
   assign acc = psel_i && penable_i && pready_reg;
   assign wr  = acc && pwrite_i;

   // word clamped to the legal floor of the active mode
   always_comb begin
      eff_word = word_reg;
      if (!chop_dis_reg && word_reg < `SDC_WORD_MIN_CHOP) begin
         eff_word = `SDC_WORD_MIN_CHOP;
      end else if (chop_dis_reg && word_reg < `SDC_WORD_MIN_BYP) begin
         eff_word = `SDC_WORD_MIN_BYP;
      end
   end
   assign dec_len  = {eff_word, 3'h0};
   assign dec_done = mod_tick_reg && samp_cnt_reg == dec_len - 11'h001;

   // bipolar sample: a one adds, a zero subtracts
   assign sample_w = mod_bit_i ? 36'sh000000001 : -36'sh000000001;
   assign comb_w[0] = integ_reg[2];

   // three integrators and three combs of the sinc3
   // the window spans three outputs, so an unaligned step shows fully on the fourth
   for (genvar k = 0; k < 3; k++) begin : g_stage
      assign comb_w[k+1] = comb_w[k] - dly_reg[k];
      always_ff @(posedge sys_clk_i) begin
         if (!resetn_i || restart_reg) begin
            integ_reg[k] <= '0;
            dly_reg[k]   <= '0;
         end else begin
            if (mod_tick_reg) begin
               integ_reg[k] <= integ_reg[k] + ((k == 0) ? sample_w : integ_reg[(k+2)%3]);
            end
            if (dec_done) begin
               dly_reg[k] <= comb_w[k];
            end
         end
      end
   end

   // decimation counter
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i || restart_reg || dec_done) begin
         samp_cnt_reg <= 11'h000;
      end else if (mod_tick_reg) begin
         samp_cnt_reg <= samp_cnt_reg + 11'h001;
      end
   end

   // chop mode lets the sinc3 settle three outputs per polarity, hence 24x word
   assign conv_done = dec_done && (chop_dis_reg || phase_reg == sdc_pkg::PH_THIRD);
   assign filt_w    = pol_reg ? -comb_w[3] : comb_w[3];
   assign avg_w     = (filt_w + prev_reg) >>> 1;
   assign conv_w    = chop_dis_reg ? comb_w[3] : avg_w;
   assign settled   = settle_reg == (chop_dis_reg ? `SDC_SETTLE_BYP : `SDC_SETTLE_CHOP);
   assign result_wr = conv_done && settled && !ready_reg;

   // sub-period phase within one chopped conversion
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i || restart_reg) begin
         phase_reg <= sdc_pkg::PH_FIRST;
      end else if (dec_done && !chop_dis_reg) begin
         case (phase_reg)
            sdc_pkg::PH_FIRST:  phase_reg <= sdc_pkg::PH_SECOND;
            sdc_pkg::PH_SECOND: phase_reg <= sdc_pkg::PH_THIRD;
            default:            phase_reg <= sdc_pkg::PH_FIRST;
         endcase
      end
   end

   // polarity reversal, previous output and settling count
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i || restart_reg) begin
         pol_reg    <= 1'b0;
         prev_reg   <= '0;
         settle_reg <= 2'h0;
      end else if (conv_done) begin
         pol_reg  <= chop_dis_reg ? 1'b0 : !pol_reg;
         prev_reg <= filt_w;
         if (!settled) begin
            settle_reg <= settle_reg + 2'h1;
         end
      end
   end

   // result register, frozen while ready stays set
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         result_reg <= 24'h000000;
      end else if (result_wr) begin
         result_reg <= conv_w[34:11];
      end
   end

   // ready flag: a new result wins over a clear in the same cycle
   always_comb begin
      ready_next = ready_reg;
      if (wr && paddr_i == `SDC_OFF_STATUS && pwdata_i[`SDC_STAT_READY]) begin
         ready_next = 1'b0;
      end
      if (wr && paddr_i == `SDC_OFF_MODE) begin
         ready_next = 1'b0;
      end
      if (result_wr) begin
         ready_next = 1'b1;
      end
   end

   // software registers and restart pulse
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         chop_dis_reg <= 1'b0;
         config_reg   <= 8'h00;
         word_reg     <= `SDC_WORD_RESET;
         mask_reg     <= 1'b0;
         ready_reg    <= 1'b0;
         restart_reg  <= 1'b0;
      end else begin
         ready_reg   <= ready_next;
         restart_reg <= wr && (paddr_i == `SDC_OFF_MODE || paddr_i == `SDC_OFF_CONFIG
                        || paddr_i == `SDC_OFF_WORD);
         if (wr && paddr_i == `SDC_OFF_MODE) begin
            chop_dis_reg <= pwdata_i[`SDC_MODE_CHOP_DIS];
         end
         if (wr && paddr_i == `SDC_OFF_CONFIG) begin
            config_reg <= pwdata_i[7:0];
         end
         if (wr && paddr_i == `SDC_OFF_WORD) begin
            word_reg <= pwdata_i[7:0];
         end
         if (wr && paddr_i == `SDC_OFF_MASK) begin
            mask_reg <= pwdata_i[`SDC_STAT_READY];
         end
      end
   end

   // read mux; unmapped addresses read zero and flag an error
   always_comb begin
      mapped  = 1'b1;
      rdata_w = 32'h00000000;
      case (paddr_i)
         `SDC_OFF_MODE:   rdata_w[`SDC_MODE_CHOP_DIS] = chop_dis_reg;
         `SDC_OFF_CONFIG: rdata_w[7:0] = config_reg;
         `SDC_OFF_WORD:   rdata_w[7:0] = word_reg;
         `SDC_OFF_RESULT: rdata_w[23:0] = result_reg;
         `SDC_OFF_STATUS: rdata_w[`SDC_STAT_READY] = ready_reg;
         `SDC_OFF_MASK:   rdata_w[`SDC_STAT_READY] = mask_reg;
         default:         mapped = 1'b0;
      endcase
   end

   // apb answer and interrupt flops
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
         irq_reg     <= 1'b0;
      end else begin
         pready_reg  <= psel_i && penable_i && !pready_reg;
         pslverr_reg <= psel_i && penable_i && !pready_reg && !mapped;
         prdata_reg  <= (psel_i && penable_i && !pready_reg && !pwrite_i) ? rdata_w : 32'h0;
         irq_reg     <= ready_reg && mask_reg;
      end
   end

   assign prdata_o   = prdata_reg;
   assign pready_o   = pready_reg;
   assign pslverr_o  = pslverr_reg;
   assign mod_tick_o = mod_tick_reg;
   assign chop_pol_o = pol_reg;
   assign range_o    = config_reg[2:0];
   assign channel_o  = config_reg[7:4];
   assign irq_o      = irq_reg;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_write_word;
      wr && paddr_i == `SDC_OFF_WORD;
   endsequence
   sequence s_restart_seen;
      restart_reg ##1 (settle_reg == 2'h0);
   endsequence

   a_word_restart: assert property (s_write_word |=> s_restart_seen)
      else $error("word write did not restart settling");
   a_ratio_eight: assert property (dec_done && word_reg >= 8'h0d
      |-> samp_cnt_reg == {word_reg, 3'h0} - 11'h001)
      else $error("decimation length not eight times word");
   a_tick_spacing: assert property (mod_tick_reg |=> !mod_tick_reg [*8])
      else $error("modulator ticks too close");
   a_chop_floor: assert property (!chop_dis_reg && word_reg < 8'h0d
      |-> eff_word == 8'h0d)
      else $error("chop word not clamped to 13");
   a_pol_flip: assert property (conv_done && !chop_dis_reg && !restart_reg
      |=> pol_reg != $past(pol_reg))
      else $error("polarity did not reverse");
   a_bypass_pol: assert property (chop_dis_reg && conv_done |=> !pol_reg)
      else $error("polarity moved while chop bypassed");
   a_result_hold: assert property (ready_reg ##1 ready_reg |-> $stable(result_reg))
      else $error("result changed while ready set");
   a_settle_gate: assert property (result_wr
      |-> settle_reg == (chop_dis_reg ? 2'h2 : 2'h1))
      else $error("result written before settling");
   a_word_reset: assert property ($past(!resetn_i) |-> word_reg == 8'h45)
      else $error("word reset value wrong");
   a_irq_level: assert property (ready_reg && mask_reg |=> irq_o)
      else $error("interrupt missing");

   // bypass words below 3 must still count a 24-sample window
   a_bypass_floor: assert property (dec_done && chop_dis_reg && word_reg < 8'h03
      |-> samp_cnt_reg == 11'h017)
      else $error("bypass word not clamped to 3");
   a_ready_set: assert property (result_wr |=> ready_reg)
      else $error("ready not set by new result");
   a_mode_clear: assert property (wr && paddr_i == `SDC_OFF_MODE && !result_wr
      |=> !ready_reg)
      else $error("mode write did not clear ready");
   a_w1c_clear: assert property (wr && paddr_i == `SDC_OFF_STATUS && pwdata_i[0] && !result_wr
      |=> !ready_reg)
      else $error("status write of one did not clear ready");
endmodule

/* File: test/sdc_mod_model.sv */
// behavioural modulator that feeds the decimator one bit per sample
`timescale 1ns/1ps
module sdc_mod_model (
   input  wire logic sys_clk_i,
   input  wire logic pol_i,
   input  wire logic level_i,
   output logic      mod_bit_o
);
   // reversal flips the stream sign, so the design must undo it
   always_ff @(posedge sys_clk_i) begin
      mod_bit_o <= level_i ^ pol_i; // single-bit density stream
   end
endmodule

/* File: test/sdc_decimator_tb.sv */
// self-checking bench for the decimator: registers, tick rate, conversion, irq
`timescale 1ns/1ps
`include "sdc_consts.svh"
module sdc_decimator_tb;
   logic        sys_clk_i, resetn_i, psel_i, penable_i, pwrite_i, level, err;
   logic        mod_bit_i, pready_o, pslverr_o, mod_tick_o, chop_pol_o, irq_o;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [2:0]  range_o;
   logic [3:0]  channel_o;
   int          n_errors, total_checks, cycles, n;

   sdc_decimator i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .mod_bit_i(mod_bit_i), .mod_tick_o(mod_tick_o), .chop_pol_o(chop_pol_o),
      .range_o(range_o), .channel_o(channel_o), .irq_o(irq_o));
   sdc_mod_model i_mod (.sys_clk_i(sys_clk_i), .pol_i(chop_pol_o), .level_i(level),
      .mod_bit_o(mod_bit_i));

   // free-running clock, 10 ns period
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   // hang guard: one conversion needs about 220k cycles
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 300000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do @(posedge sys_clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic t_reset();
      apb(1'b0, `SDC_OFF_WORD, '0);
      check(rd, 32'h00000045, "word reset");
      check({31'h0, err}, 32'h00000000, "mapped read no err");
      apb(1'b0, `SDC_OFF_MODE, '0);
      check(rd, 32'h00000000, "mode reset, chop on");
      apb(1'b0, `SDC_OFF_MASK, '0);
      check(rd, 32'h00000000, "mask reset");
      $display("test reset done");
   endtask

   task automatic t_regs();
      apb(1'b1, `SDC_OFF_CONFIG, 32'h000000a5);
      @(posedge sys_clk_i);
      check({29'h0, range_o}, 32'h00000005, "range out");
      check({28'h0, channel_o}, 32'h0000000a, "channel out");
      apb(1'b1, `SDC_OFF_WORD, 32'h00000005);
      apb(1'b0, `SDC_OFF_WORD, '0);
      check(rd, 32'h00000005, "chop word below floor kept");
      apb(1'b1, 8'h18, 32'hffffffff);
      check({31'h0, err}, 32'h00000001, "unmapped write err");
      apb(1'b0, 8'h18, '0);
      check(rd, 32'h00000000, "unmapped read data");
      $display("test regs done");
   endtask

   // modulator tick spacing at 32.768 kHz from 100 MHz
   task automatic t_tick();
      do @(posedge sys_clk_i); while (mod_tick_o !== 1'b1);
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (mod_tick_o !== 1'b1);
      check(n, 32'd3051, "tick period");
      $display("test tick done");
   endtask

   // bypass, word 1 clamps to 3: third output after restart is stored, 24^3 >> 11 = 6
   task automatic t_conv();
      apb(1'b1, `SDC_OFF_MASK, 32'h1);
      // range stays fixed while bypassed, so no recalibration is owed
      apb(1'b1, `SDC_OFF_MODE, 32'h8);
      check({31'h0, chop_pol_o}, 32'h0, "no reversal in bypass");
      apb(1'b1, `SDC_OFF_WORD, 32'h1);
      n = 0;
      while (irq_o !== 1'b1) begin
         @(posedge sys_clk_i);
         if (mod_tick_o === 1'b1) n++;
      end
      check({31'h0, chop_pol_o}, 32'h0, "no reversal after bypass outputs");
      check({31'h0, n >= 71 && n <= 73}, 32'h1, "ticks to third output");
      apb(1'b0, `SDC_OFF_RESULT, '0);
      check(rd, 32'h00000006, "settled result");
      apb(1'b0, `SDC_OFF_STATUS, '0);
      check(rd, 32'h00000001, "ready set");
      apb(1'b1, `SDC_OFF_MASK, 32'h0);
      repeat (2) @(posedge sys_clk_i);
      check({31'h0, irq_o}, 32'h0, "irq masked");
      apb(1'b1, `SDC_OFF_MASK, 32'h1);
      repeat (2) @(posedge sys_clk_i);
      check({31'h0, irq_o}, 32'h1, "irq unmasked");
      apb(1'b1, `SDC_OFF_STATUS, 32'h1);
      repeat (2) @(posedge sys_clk_i);
      check({31'h0, irq_o}, 32'h0, "irq cleared");
      $display("test conversion done");
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // reset held two cycles, then the scenarios in order
   initial begin
      resetn_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h00000000;
      level = 1'b1;
      repeat (2) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      t_reset();
      t_regs();
      t_tick();
      t_conv();
      give_verdict();
   end
endmodule
